/* rtl/cmo_gate.sv */
// loss monitor, parking and glitch-free output gating of the clock mux
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
//
// Contract
// - watch input clock, flag loss when gone
// - loss pulls open-drain flag, sets sticky event
// - flag low from reset until clock valid
// - monitor only the selected input clock
// - loss parks clock path low/low
// - output runs only if all enables agree
// - enable changes synchronised, no runt pulses
// - one bus enable bit per output, reset enabled
// - bus bit zero stops low/low, one restarts
// - enable sync clocked by input clock; here run_q is a pclk flop loaded on the sampled falling edge
// - pin low enables, high disables low/low
// - up to eight active-low enable pins
// - strap shares four pins with sideband port
// - latch input reuses two pins on small variants
// - strap one turns pins d,e,g,h sideband
// - 16/8-output pin to output mapping
// - 4/2-output pin to output mapping
// - event bit cleared only by writing one
module cmo_gate #(
  parameter logic [1:0] VARIANT = cmo_pkg::VAR_16
) (
  input wire logic pclk, // apb clock, 50 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [1:0] ref_clock_in, // the two input clocks
  input wire logic ref_select, // input clock choice
  input wire logic [7:0] output_enable_n, // enable pins a..h, low enables
  input wire logic sideband_enable_strap, // strap, 1 gives pins to sideband port
  input wire logic mgmt_bus_enable_latch_n, // low gives pins b,g to the bus
  input wire logic [15:0] sideband_enables, // enables from the sideband register
  output logic [15:0] clk_true, // true legs
  output logic [15:0] clk_comp, // complementary legs
  output logic signal_loss_flag_n_out, // open-drain flag, output level
  output logic signal_loss_flag_n_oe, // open-drain flag, drive enable
  output logic irq // level interrupt
);
  localparam int LOSS_CYC = cmo_pkg::LOSS_CYC;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [28:0] s1_q, s2_q, s3_q, pin_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= cmo_pkg::RST_SYNC;
      s2_q <= cmo_pkg::RST_SYNC;
      s3_q <= cmo_pkg::RST_SYNC;
      pin_q <= cmo_pkg::RST_SYNC;
    end else begin
      s1_q <= {sideband_enables, mgmt_bus_enable_latch_n, sideband_enable_strap,
               output_enable_n, ref_select, ref_clock_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
      // a bit moves only when the second and third stage agree
      pin_q <= (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));
    end
  end

  logic [1:0] ref_lvl;
  logic sel_lvl;
  logic [7:0] pin_n;
  logic [15:0] sb_en;
  assign ref_lvl = pin_q[1:0];
  assign sel_lvl = pin_q[2];
  assign pin_n = pin_q[10:3];
  assign sb_en = pin_q[28:13];

  // ----------------------------------------------------------------
  // strap capture after reset release
  // ----------------------------------------------------------------
  logic [1:0] strap_cnt_q;
  logic strap_q, bus_pins_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_q <= 2'h0;
      strap_q <= 1'b0;
      bus_pins_q <= 1'b0;
    end else if (strap_cnt_q != 2'(cmo_pkg::STRAP_WAIT)) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
    end else if (strap_cnt_q == 2'(cmo_pkg::STRAP_WAIT) && !strap_q && !bus_pins_q) begin
      // straps are static after power-up; sampling repeats each cycle until strap_q or bus_pins_q is set, then holds
      // pin_q still holds its reset value here; the agreeing stages already carry the pin
      strap_q <= (VARIANT == cmo_pkg::VAR_16 || VARIANT == cmo_pkg::VAR_8) && s2_q[11] && s3_q[11];
      bus_pins_q <= (VARIANT == cmo_pkg::VAR_4 || VARIANT == cmo_pkg::VAR_2) && !s2_q[12] && !s3_q[12];
    end
  end

  // ----------------------------------------------------------------
  // loss monitor on the selected input
  // ----------------------------------------------------------------
  logic ref_now, ref_prev_q, sel_prev_q, ref_edge, fall_edge;
  assign ref_now = sel_lvl ? ref_lvl[1] : ref_lvl[0];
  assign ref_edge = (ref_now != ref_prev_q) && (sel_lvl == sel_prev_q);
  assign fall_edge = ref_prev_q && !ref_now && (sel_lvl == sel_prev_q);

  logic [7:0] idle_cnt_q;
  logic [2:0] good_cnt_q;
  logic loss_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_prev_q <= 1'b0;
      sel_prev_q <= 1'b0;
      idle_cnt_q <= 8'h00;
      good_cnt_q <= 3'h0;
      loss_q <= 1'b1;
    end else begin
      ref_prev_q <= ref_now;
      sel_prev_q <= sel_lvl;
      if (ref_edge) begin
        idle_cnt_q <= 8'h00;
      end else if (idle_cnt_q != 8'(LOSS_CYC)) begin
        idle_cnt_q <= idle_cnt_q + 8'h01;
      end
      if (!ref_edge && idle_cnt_q == 8'(LOSS_CYC - 1)) begin
        loss_q <= 1'b1;
        good_cnt_q <= 3'h0;
      end else if (loss_q && fall_edge) begin
        // several clean edges are required before the flag releases
        if (good_cnt_q == 3'(cmo_pkg::VALID_EDGES - 1)) begin
          loss_q <= 1'b0;
          good_cnt_q <= 3'h0;
        end else begin
          good_cnt_q <= good_cnt_q + 3'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pin to output mapping
  // ----------------------------------------------------------------
  // returns {valid, output index} for one enable pin
  function automatic logic [4:0] pin_target(input logic [2:0] p, input logic [7:0] remap);
    logic [4:0] t;
    t = 5'h00;
    unique case (VARIANT)
      cmo_pkg::VAR_16: t = {1'b1, p, remap[p]};
      cmo_pkg::VAR_8: t = {1'b1, p, p[0]};
      cmo_pkg::VAR_4: begin
        unique case (p)
          3'h1: t = remap[1] ? 5'h15 : 5'h13;
          3'h2: t = 5'h15;
          3'h5: t = 5'h1a;
          3'h6: t = remap[6] ? 5'h1a : 5'h1c;
          default: t = 5'h00;
        endcase
      end
      cmo_pkg::VAR_2: t = (p == 3'h2) ? 5'h15 : (p == 3'h5) ? 5'h1a : 5'h00;
    endcase
    return t;
  endfunction

  logic [15:0] present, pin_ok;
  logic [7:0] remap_q;
  always_comb begin
    logic [4:0] tgt;
    logic as_enable;
    tgt = 5'h00;
    as_enable = 1'b0;
    present = 16'h0000;
    pin_ok = 16'hffff;
    for (int p = 0; p < cmo_pkg::NUM_PIN; p++) begin
      tgt = pin_target(3'(p), remap_q);
      // pins d,e,g,h serve the sideband port, b,g the bus on small parts
      as_enable = !(strap_q && (p == 3 || p == 4 || p == 6 || p == 7)) &&
                  !(bus_pins_q && (p == 1 || p == 6));
      if (tgt[4]) begin
        present[tgt[3:0]] = 1'b1;
        if (as_enable && pin_n[p]) begin
          pin_ok[tgt[3:0]] = 1'b0;
        end
      end
    end
    if (VARIANT == cmo_pkg::VAR_4) begin
      present = 16'h1428;
    end
    // every output of the full part exists, pin or no pin
    if (VARIANT == cmo_pkg::VAR_16) begin
      present = 16'hffff;
    end
  end

  // ----------------------------------------------------------------
  // glitch-free output gating
  // ----------------------------------------------------------------
  logic [15:0] out_en_q, want, run_q, sb_ok;
  assign sb_ok = strap_q ? sb_en : 16'hffff;
  assign want = out_en_q & pin_ok & sb_ok & present;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 16'h0000;
    end else if (loss_q) begin
      run_q <= 16'h0000;
    end else if (fall_edge) begin
      // switching only while the clock is low keeps every pulse whole
      run_q <= want;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_true <= 16'h0000;
      clk_comp <= 16'h0000;
    end else begin
      clk_true <= loss_q ? 16'h0000 : run_q & {16{ref_now}};
      clk_comp <= loss_q ? 16'h0000 : run_q & {16{!ref_now}};
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic setup, acc_wr, hit;
  assign setup = psel && !penable;
  assign acc_wr = psel && penable && pready && pwrite;
  assign hit = paddr inside {cmo_pkg::OFS_OUT_ENABLE, cmo_pkg::OFS_PIN_REMAP, cmo_pkg::OFS_EVT_STATUS,
                             cmo_pkg::OFS_EVT_CLEAR, cmo_pkg::OFS_EVT_ENABLE, cmo_pkg::OFS_LIVE_STATE,
                             cmo_pkg::OFS_RUN_STATE};

  logic [1:0] evt_q, evt_en_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_en_q <= cmo_pkg::RST_OUT_ENABLE;
      remap_q <= cmo_pkg::RST_PIN_REMAP;
      evt_en_q <= cmo_pkg::RST_EVT;
    end else if (acc_wr) begin
      if (paddr == cmo_pkg::OFS_OUT_ENABLE) begin
        out_en_q <= pwdata[15:0];
      end
      if (paddr == cmo_pkg::OFS_PIN_REMAP) begin
        remap_q <= pwdata[7:0];
      end
      if (paddr == cmo_pkg::OFS_EVT_ENABLE) begin
        evt_en_q <= pwdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------
  logic loss_prev_q;
  logic [1:0] evt_set, evt_clr;
  assign evt_set = {loss_prev_q && !loss_q, !loss_prev_q && loss_q};
  assign evt_clr = (acc_wr && paddr == cmo_pkg::OFS_EVT_CLEAR) ? pwdata[1:0] : 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loss_prev_q <= 1'b1;
      evt_q <= cmo_pkg::RST_EVT;
      irq <= 1'b0;
      signal_loss_flag_n_out <= 1'b0;
      signal_loss_flag_n_oe <= 1'b1;
    end else begin
      loss_prev_q <= loss_q;
      // a new event in the clearing cycle survives the clear
      evt_q <= (evt_q & ~evt_clr) | evt_set;
      irq <= |(evt_q & evt_en_q);
      signal_loss_flag_n_out <= 1'b0;
      signal_loss_flag_n_oe <= loss_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !hit;
      if (setup && !pwrite) begin
        unique case (paddr)
          cmo_pkg::OFS_OUT_ENABLE: prdata <= {16'h0000, out_en_q};
          cmo_pkg::OFS_PIN_REMAP: prdata <= {24'h000000, remap_q};
          cmo_pkg::OFS_EVT_STATUS: prdata <= {30'h0, evt_q};
          cmo_pkg::OFS_EVT_ENABLE: prdata <= {30'h0, evt_en_q};
          cmo_pkg::OFS_LIVE_STATE: prdata <= {27'h0, bus_pins_q, strap_q, sel_lvl, ref_now, loss_q};
          cmo_pkg::OFS_RUN_STATE: prdata <= {16'h0000, run_q};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_loss_flag;
    @(posedge pclk) disable iff (!presetn) $rose(loss_q) |=> signal_loss_flag_n_oe && evt_q[0];
  endproperty
  a_loss_flag: assert property (p_loss_flag) else $error("loss not flagged");

  property p_loss_timeout;
    @(posedge pclk) disable iff (!presetn)
      (!ref_edge && idle_cnt_q == 8'(LOSS_CYC - 1)) |=> loss_q;
  endproperty
  a_loss_timeout: assert property (p_loss_timeout) else $error("timeout missed");

  property p_park;
    @(posedge pclk) disable iff (!presetn) loss_q |=> (clk_true == 16'h0000 && clk_comp == 16'h0000);
  endproperty
  a_park: assert property (p_park) else $error("outputs not parked");

  property p_stopped_low;
    @(posedge pclk) disable iff (!presetn) 1'b1 |=> ((clk_true | clk_comp) & ~$past(run_q)) == 16'h0000;
  endproperty
  a_stopped_low: assert property (p_stopped_low) else $error("stopped output toggles");

  property p_sync_change;
    @(posedge pclk) disable iff (!presetn)
      (run_q != $past(run_q)) |-> ($past(fall_edge) || $past(loss_q));
  endproperty
  a_sync_change: assert property (p_sync_change) else $error("unsynchronised enable");

  property p_bus_enable;
    @(posedge pclk) disable iff (!presetn)
      (acc_wr && paddr == cmo_pkg::OFS_OUT_ENABLE) |=> out_en_q == $past(pwdata[15:0]);
  endproperty
  a_bus_enable: assert property (p_bus_enable) else $error("enable write lost");

  property p_evt_hold;
    @(posedge pclk) disable iff (!presetn) (evt_q[0] && !evt_clr[0]) |=> evt_q[0];
  endproperty
  a_evt_hold: assert property (p_evt_hold) else $error("event bit dropped");

  property p_run_needs_want;
    @(posedge pclk) disable iff (!presetn) fall_edge && !loss_q |=> run_q == $past(want);
  endproperty
  a_run_needs_want: assert property (p_run_needs_want) else $error("run ignores enables");

  property p_flag_reset;
    @(posedge pclk) disable iff (!presetn) $rose(presetn) |-> signal_loss_flag_n_oe ##1 loss_q;
  endproperty
  a_flag_reset: assert property (p_flag_reset) else $error("flag released at reset");

  property p_enable_reset;
    @(posedge pclk) disable iff (!presetn) $rose(presetn) |-> out_en_q == cmo_pkg::RST_OUT_ENABLE;
  endproperty
  a_enable_reset: assert property (p_enable_reset) else $error("bus enables not reset enabled");

  property p_pin_disable;
    @(posedge pclk) disable iff (!presetn) fall_edge && !loss_q |=> (run_q & ~$past(pin_ok)) == 16'h0000;
  endproperty
  a_pin_disable: assert property (p_pin_disable) else $error("disabled pin output runs");

  property p_absent_low;
    @(posedge pclk) disable iff (!presetn) ((clk_true | clk_comp) & ~present) == 16'h0000;
  endproperty
  a_absent_low: assert property (p_absent_low) else $error("absent output toggles");

  property p_select_quiet;
    @(posedge pclk) disable iff (!presetn) (sel_lvl != sel_prev_q) |-> !ref_edge && !fall_edge;
  endproperty
  a_select_quiet: assert property (p_select_quiet) else $error("edge seen across selection change");

  c_recover: cover property (@(posedge pclk) disable iff (!presetn) $fell(loss_q));
  c_loss: cover property (@(posedge pclk) disable iff (!presetn) $rose(loss_q));
  c_bus_stop: cover property (@(posedge pclk) disable iff (!presetn)
    acc_wr && paddr == cmo_pkg::OFS_OUT_ENABLE && pwdata[0] == 1'b0);
  c_strap: cover property (@(posedge pclk) disable iff (!presetn) strap_q && fall_edge && !loss_q);
endmodule : cmo_gate

/* rtl/cmo_pkg.sv */
// constants and register map of the clock mux output gating block
package cmo_pkg;
  localparam int NUM_OUT = 16;
  localparam int NUM_PIN = 8;
  localparam int NUM_SYNC = 29;

  // product variants selected by the top-level parameter
  localparam logic [1:0] VAR_16 = 2'h0;
  localparam logic [1:0] VAR_8 = 2'h1;
  localparam logic [1:0] VAR_4 = 2'h2;
  localparam logic [1:0] VAR_2 = 2'h3;

  // apb register byte offsets
  localparam logic [7:0] OFS_OUT_ENABLE = 8'h00;
  localparam logic [7:0] OFS_PIN_REMAP = 8'h04;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h08;
  localparam logic [7:0] OFS_EVT_CLEAR = 8'h0c;
  localparam logic [7:0] OFS_EVT_ENABLE = 8'h10;
  localparam logic [7:0] OFS_LIVE_STATE = 8'h14;
  localparam logic [7:0] OFS_RUN_STATE = 8'h18;

  // event bit positions
  localparam int EVT_LOSS = 0;
  localparam int EVT_RECOVER = 1;
  localparam int NUM_EVT = 2;

  // reset values
  localparam logic [15:0] RST_OUT_ENABLE = 16'hffff;
  localparam logic [7:0] RST_PIN_REMAP = 8'h00;
  localparam logic [1:0] RST_EVT = 2'h0;
  // sync order: sideband[28:13], latch_n[12], strap[11], pins_n[10:3], select[2], ref[1:0]
  localparam logic [28:0] RST_SYNC = 29'h1ffff7f8;

  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int LOSS_TIMEOUT_NS = 1000;
  localparam int LOSS_CYC = (LOSS_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VALID_EDGES = 4;
  localparam int STRAP_WAIT = 3;
endpackage : cmo_pkg

/* testbench/cmo_ctrl_model.sv */
// partner model: system controller driving reference clocks and enable pins
`timescale 1ns/1ns
module cmo_ctrl_model (
  input wire logic pclk, // bench clock
  input wire logic [1:0] run, // start or stop each reference clock
  input wire logic [7:0] pin_en, // wanted enable per pin, 1 = enabled
  output logic [1:0] ref_clock_in, // reference clocks, held low while stopped
  output logic [7:0] output_enable_n // enable pins a..h, low enables
);
  // periods are not multiples of pclk, so edges drift against it
  initial ref_clock_in = 2'h0;
  always #95 ref_clock_in[0] = run[0] ? ~ref_clock_in[0] : 1'b0;
  always #85 ref_clock_in[1] = run[1] ? ~ref_clock_in[1] : 1'b0;
  initial output_enable_n = 8'hff;
  always @(posedge pclk) output_enable_n <= ~pin_en;
endmodule : cmo_ctrl_model

/* testbench/cmo_gate_tb.sv */
// self-checking bench of the clock mux output gating block
`timescale 1ns/1ns
module cmo_gate_tb;
  logic pclk, presetn, psel, penable, pwrite, ref_select, pready, pslverr, flag_out, flag_oe, irq, strap;
  logic [15:0] sb_en;
  logic [7:0] paddr, pin_en, oe_n;
  logic [31:0] pwdata, prdata, rnd;
  logic [1:0] ref_clk, run;
  logic [15:0] clk_true, clk_comp;
  logic [32:0] expq[$];
  int n_fail, total_checks;

  cmo_gate #(.VARIANT(cmo_pkg::VAR_16)) cmo_gate_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_clock_in(ref_clk), .ref_select(ref_select), .output_enable_n(oe_n),
    .sideband_enable_strap(strap), .mgmt_bus_enable_latch_n(1'b1), .sideband_enables(sb_en),
    .clk_true(clk_true), .clk_comp(clk_comp), .signal_loss_flag_n_out(flag_out),
    .signal_loss_flag_n_oe(flag_oe), .irq(irq));

  cmo_ctrl_model cmo_ctrl_model_inst (.pclk(pclk), .run(run), .pin_en(pin_en), .ref_clock_in(ref_clk),
    .output_enable_n(oe_n));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // slave answer time is not assumed; the wait is bounded
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] exp);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) expq.push_back(exp);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk(1'b0, "no ready");
      report_and_stop();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, d, {1'b0, d});
  endtask : rd

  // sampled mid-cycle so the design's edge updates have landed
  task automatic out_runs(input int i, input logic exp_run);
    logic ok, tog, last;
    ok = 1'b1;
    tog = 1'b0;
    last = clk_true[i];
    repeat (40) begin
      @(negedge pclk);
      if (exp_run) ok &= (clk_comp[i] === ~clk_true[i]);
      else ok &= (clk_true[i] === 1'b0 && clk_comp[i] === 1'b0);
      tog |= (clk_true[i] !== last);
      last = clk_true[i];
    end
    chk(ok && (tog === exp_run), "output state");
  endtask : out_runs

  task automatic wait_flag(input logic v);
    int n;
    n = 0;
    while (flag_oe !== v && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk(flag_oe === v, "loss flag");
    if (flag_oe !== v) report_and_stop();
  endtask : wait_flag

  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (expq.size() == 0) chk(1'b0, "unexpected read");
      else chk({pslverr, prdata} === expq.pop_front(), "read data");
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ref_select = 1'b0;
    run = 2'h0;
    pin_en = 8'hff;
    strap = 1'b0;
    sb_en = 16'hffff;
    rnd = 32'hc66dc8a2;
    n_fail = 0;
    total_checks = 0;
    repeat (6) @(posedge pclk);
    chk(flag_oe === 1'b1 && clk_true === 16'h0, "reset state");
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(flag_oe === 1'b1, "flag before clock");
    run <= 2'h1;
    wait_flag(1'b0);
    rd(cmo_pkg::OFS_OUT_ENABLE, 32'hffff);
    apb(1'b0, 8'h1c, 32'h0, {1'b1, 32'h0});
    repeat (30) @(posedge pclk);
    out_runs(0, 1'b1);
    rnd = lfsr(rnd);
    wr(cmo_pkg::OFS_OUT_ENABLE, {16'h0, rnd[15:0] & 16'hfffe | 16'h0010});
    rd(cmo_pkg::OFS_OUT_ENABLE, {16'h0, rnd[15:0] & 16'hfffe | 16'h0010});
    repeat (30) @(posedge pclk);
    out_runs(0, 1'b0);
    out_runs(4, 1'b1);
    wr(cmo_pkg::OFS_OUT_ENABLE, 32'hffff);
    repeat (30) @(posedge pclk);
    out_runs(0, 1'b1);
    pin_en <= 8'hfd;
    repeat (30) @(posedge pclk);
    out_runs(2, 1'b0);
    out_runs(3, 1'b1);
    wr(cmo_pkg::OFS_PIN_REMAP, 32'h2);
    rd(cmo_pkg::OFS_PIN_REMAP, 32'h2);
    repeat (30) @(posedge pclk);
    out_runs(3, 1'b0);
    out_runs(2, 1'b1);
    pin_en <= 8'hff;
    wr(cmo_pkg::OFS_EVT_CLEAR, 32'h3);
    rd(cmo_pkg::OFS_EVT_STATUS, 32'h0);
    wr(cmo_pkg::OFS_EVT_ENABLE, 32'h1);
    run <= 2'h2;
    wait_flag(1'b1);
    out_runs(0, 1'b0);
    rd(cmo_pkg::OFS_EVT_STATUS, 32'h1);
    chk(irq === 1'b1, "irq raised");
    rnd = lfsr(rnd);
    wr(cmo_pkg::OFS_EVT_CLEAR, rnd & 32'hfffffffe);
    rd(cmo_pkg::OFS_EVT_STATUS, 32'h1);
    wr(cmo_pkg::OFS_EVT_CLEAR, 32'h1);
    rd(cmo_pkg::OFS_EVT_STATUS, 32'h0);
    repeat (2) @(posedge pclk);
    chk(irq === 1'b0, "irq cleared");
    ref_select <= 1'b1;
    wait_flag(1'b0);
    repeat (30) @(posedge pclk);
    out_runs(0, 1'b1);
    ref_select <= 1'b0;
    wait_flag(1'b1);
    rd(cmo_pkg::OFS_EVT_STATUS, 32'h3);
    wr(cmo_pkg::OFS_EVT_ENABLE, 32'h0);
    repeat (2) @(posedge pclk);
    chk(irq === 1'b0, "irq masked");
    // mid-run reset with the strap up: pin d no longer gates, the sideband vector does
    strap <= 1'b1;
    sb_en <= 16'hfeff;
    pin_en <= 8'hf7;
    ref_select <= 1'b1;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(flag_oe === 1'b1 && clk_true === 16'h0, "reset state");
    presetn <= 1'b1;
    wait_flag(1'b0);
    repeat (30) @(posedge pclk);
    out_runs(6, 1'b1);
    out_runs(8, 1'b0);
    rd(cmo_pkg::OFS_RUN_STATE, 32'hfeff);
    report_and_stop();
  end
endmodule : cmo_gate_tb
